// ==== design/scpr_pkg.sv ====
// scpr_pkg: shared constants and carriers for the serial configuration readout block
// assumes a single 50 MHz clock domain; all pin inputs except the programming port are synchronised in the top module
package scpr_pkg;
    localparam int          SCPR_CLK_HZ        = 50_000_000;
    localparam int          SCPR_ADDR_W        = 12;
    localparam int          SCPR_MEM_DEPTH     = 4096;
    localparam logic [11:0] SCPR_LAST_ADDR     = 12'hFFF;
    localparam logic [11:0] SCPR_ADDR_RST      = 12'h000;
    localparam int          SCPR_POR_NS        = 2000;
    localparam int          SCPR_POR_CYC       = (SCPR_POR_NS * 50 + 999) / 1000;
    localparam int          SCPR_CFG_PULSE_NS  = 300;
    localparam int          SCPR_CFG_PULSE_CYC = (SCPR_CFG_PULSE_NS * 50 + 999) / 1000;
    localparam int          SCPR_CNT_W         = 8;
    localparam int          SCPR_BUF_DEPTH     = 2;
    localparam logic [3:0]  SCPR_TAP_RESET_ST  = 4'h0;

    typedef enum logic [1:0] {
        SCPR_ST_POR   = 2'b00,
        SCPR_ST_IDLE  = 2'b01,
        SCPR_ST_READ  = 2'b11,
        SCPR_ST_DONE  = 2'b10
    } scpr_state_e;

    typedef struct packed {
        logic out;
        logic oe;
    } scpr_pin_s;

    typedef struct packed {
        logic                   bit_val;
        logic [SCPR_ADDR_W-1:0] addr;
    } scpr_word_s;
endpackage

// ==== design/scpr_buf.sv ====
// scpr_buf: two-entry valid/ready buffer between the bit store and the data pin
// assumes same clock and reset as the top module
`timescale 1ns/1ns
module scpr_buf
    import scpr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       flush_i,
    input  wire scpr_word_s in_data_i,
    input  wire logic       in_valid_i,
    output logic            in_ready_o,
    output scpr_word_s      out_data_o,
    output logic            out_valid_o,
    input  wire logic       out_ready_i
);
    scpr_word_s mem [SCPR_BUF_DEPTH];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    logic       push;
    logic       pop;

    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else if (flush_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // scpr_buf

// ==== design/scpr_sync.sv ====
// scpr_sync: two-flop synchroniser for a vector of pin levels
// assumes the inputs are asynchronous levels
`timescale 1ns/1ns
module scpr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] d_i,
    output logic [W-1:0]      q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // scpr_sync

// ==== design/scpr_top.sv ====
// scpr_top: serial readout, cascade select and config pulse of a configuration memory
// assumes config clock, selects and jtag pins are asynchronous to CLK_I
//
// What this block does
// - rising config clock advances address when selected, select low, enable high
// - enable/reset low holds address reset and floats serial data
// - drive enable/reset line low until power-on reset sequence finishes
// - select high: standby, address reset, data outputs floated
// - jtag configure instruction pulses open-drain config output low
// - config pulse lasts at least the minimum pulse width
// - next select low only when selected, enabled and past last address
// - next select returns high when enable low or select high
// - serial data floated during program mode unless pins are clamped
// - stored stream presented one bit at a time on serial data
// - tap state follows tms sampled on each rising tck
`timescale 1ns/1ns
module scpr_top
    import scpr_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic RSTN_I,
    input  wire logic CFG_CLK_I,
    input  wire logic CFG_CLK_SEL_I,
    input  wire logic DEV_SEL_N_I,
    input  wire logic OE_RESET_N_I,
    output logic      OE_RESET_N_O,
    output logic      OE_RESET_N_OE_O,
    output logic      SERIAL_BIT_OUT_O,
    output logic      SERIAL_BIT_OUT_OE_O,
    output logic      NEXT_DEVICE_SELECT_N_O,
    output logic      CONFIG_PULSE_N_O,
    output logic      CONFIG_PULSE_N_OE_O,
    input  wire logic IN_SYSTEM_PROGRAM_MODE_I,
    input  wire logic CLAMP_I,
    input  wire logic TCK_I,
    input  wire logic TMS_I,
    input  wire logic CONFIG_CMD_I,
    output logic [3:0] TAP_STATE_O,
    input  wire logic PROG_WE_I,
    input  wire logic [SCPR_ADDR_W-1:0] PROG_ADDR_I,
    input  wire logic PROG_BIT_I
);
    logic [6:0] pins_s;
    logic       cfg_clk_s;
    logic       cfg_sel_s;
    logic       sel_n_s;
    logic       oe_n_s;
    logic       isp_s;
    logic       clamp_s;
    logic       tck_s;
    logic       tms_s;
    logic       cmd_s;
    logic       cfg_clk_d;
    logic       tck_d;
    logic       cmd_d;
    logic       cfg_rise;
    logic       tck_rise;
    logic       cmd_rise;

    scpr_state_e            state;
    scpr_state_e            next_state;
    logic [SCPR_ADDR_W-1:0] addr;
    logic                   past_last;
    logic [11:0]            por_cnt;
    logic [SCPR_CNT_W-1:0]  pulse_cnt;
    logic                   active;
    logic                   hold_reset;
    logic                   mem [SCPR_MEM_DEPTH];
    logic [3:0]             tap_state;
    logic [3:0]             next_tap;
    logic                   step;
    logic [SCPR_ADDR_W-1:0] load_addr;
    logic                   load_done;

    scpr_word_s buf_in;
    scpr_word_s buf_out;
    logic       buf_in_ready;
    logic       buf_out_valid;
    logic       buf_out_ready;
    logic       fetch;
    scpr_pin_s  data_pin;

    // all pin levels except the programming port pass two flops before any logic reads them
    scpr_sync #(
        .W(7)
    ) u_sync (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .d_i    ({CFG_CLK_I, CFG_CLK_SEL_I, DEV_SEL_N_I, OE_RESET_N_I,
                  IN_SYSTEM_PROGRAM_MODE_I, CLAMP_I, TCK_I}),
        .q_o    (pins_s)
    );

    // tms passes the same depth as tck so both arrive aligned
    scpr_sync #(
        .W(2)
    ) u_sync_jtag (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .d_i    ({TMS_I, CONFIG_CMD_I}),
        .q_o    ({tms_s, cmd_s})
    );

    assign {cfg_clk_s, cfg_sel_s, sel_n_s, oe_n_s, isp_s, clamp_s, tck_s} = pins_s;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cfg_clk_d <= 1'b0;
            tck_d     <= 1'b0;
            cmd_d     <= 1'b0;
        end else begin
            cfg_clk_d <= cfg_clk_s;
            tck_d     <= tck_s;
            cmd_d     <= cmd_s;
        end
    end

    assign cfg_rise = cfg_clk_s && !cfg_clk_d;
    assign tck_rise = tck_s && !tck_d;
    assign cmd_rise = cmd_s && !cmd_d;

    // power-on sequence: line held low until the count expires
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            por_cnt <= 12'h000;
        end else if (state == SCPR_ST_POR) begin
            por_cnt <= por_cnt + 12'h001;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            SCPR_ST_POR: begin
                if (por_cnt >= 12'(SCPR_POR_CYC - 1)) begin
                    next_state = SCPR_ST_IDLE;
                end
            end
            SCPR_ST_IDLE: begin
                if (active) begin
                    next_state = SCPR_ST_READ;
                end
            end
            SCPR_ST_READ: begin
                if (!active) begin
                    next_state = SCPR_ST_IDLE;
                end else if (past_last) begin
                    next_state = SCPR_ST_DONE;
                end
            end
            SCPR_ST_DONE: begin
                if (!active) begin
                    next_state = SCPR_ST_IDLE;
                end
            end
            default: next_state = SCPR_ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state <= SCPR_ST_POR;
        end else begin
            state <= next_state;
        end
    end

    assign OE_RESET_N_O    = 1'b0;
    assign OE_RESET_N_OE_O = (state == SCPR_ST_POR);

    // the line may be pulled low by us or by the far side; either holds reset
    assign hold_reset = !oe_n_s || (state == SCPR_ST_POR);
    assign active     = !sel_n_s && !hold_reset;

    // one config clock rise consumes the bit at the pin; edges with nothing shown are refused
    assign step = cfg_sel_s && cfg_rise && !past_last && buf_out_valid
                  && (buf_out.addr == addr);

    // address counter; the extra flag marks an increment beyond the last address
    // it counts bits handed over, so it only moves while a bit stands at the pin
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            addr      <= SCPR_ADDR_RST;
            past_last <= 1'b0;
        end else if (!active) begin
            addr      <= SCPR_ADDR_RST;
            past_last <= 1'b0;
        end else if (step) begin
            if (addr == SCPR_LAST_ADDR) begin
                past_last <= 1'b1;
            end else begin
                addr <= addr + 12'h001;
            end
        end
    end

    // stream store, loaded through the programming port
    // program mode is a pin level, so the write gate reads its synchronised copy
    always_ff @(posedge CLK_I) begin
        if (PROG_WE_I && isp_s) begin
            mem[PROG_ADDR_I] <= PROG_BIT_I;
        end
    end

    // prefetch pointer runs ahead of the address counter to keep the buffer full
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            load_addr <= SCPR_ADDR_RST;
            load_done <= 1'b0;
        end else if (!active) begin
            load_addr <= SCPR_ADDR_RST;
            load_done <= 1'b0;
        end else if (fetch && buf_in_ready) begin
            if (load_addr == SCPR_LAST_ADDR) begin
                load_done <= 1'b1;
            end else begin
                load_addr <= load_addr + 12'h001;
            end
        end
    end

    // a word enters the buffer whenever it has room while active and until the last address is loaded; a stall holds the prefetch pointer
    assign fetch           = active && !load_done;
    assign buf_in.bit_val  = mem[load_addr];
    assign buf_in.addr     = load_addr;
    assign buf_out_ready   = step;

    scpr_buf u_buf (
        .clk_i       (CLK_I),
        .rstn_i      (RSTN_I),
        .flush_i     (!active),
        .in_data_i   (buf_in),
        .in_valid_i  (fetch),
        .in_ready_o  (buf_in_ready),
        .out_data_o  (buf_out),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_out_ready)
    );

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            data_pin <= '0;
        end else begin
            data_pin.out <= buf_out.bit_val;
            data_pin.oe  <= active && buf_out_valid && !past_last
                            && !(isp_s && !clamp_s);
        end
    end

    assign SERIAL_BIT_OUT_O    = data_pin.out;
    assign SERIAL_BIT_OUT_OE_O = data_pin.oe;

    // combinational so deselect or reset releases the next device immediately
    assign NEXT_DEVICE_SELECT_N_O = !(active && past_last);

    // config pulse stretched to the minimum width
    // a second command during a pulse restarts the full width
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pulse_cnt <= '0;
        end else if (cmd_rise) begin
            pulse_cnt <= SCPR_CNT_W'(SCPR_CFG_PULSE_CYC);
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 1'b1;
        end
    end

    assign CONFIG_PULSE_N_O    = 1'b0;
    assign CONFIG_PULSE_N_OE_O = (pulse_cnt != '0);

    // tap controller, 16-state walk sampled on tck rise; tms high in either exit2 state returns to exit1, not update
    // tck is oversampled, so it must stay well below half the system clock rate
    always_comb begin
        next_tap = tap_state;
        case (tap_state)
            4'h0: next_tap = tms_s ? 4'h0 : 4'h1;
            4'h1: next_tap = tms_s ? 4'h2 : 4'h1;
            4'h2: next_tap = tms_s ? 4'h9 : 4'h3;
            4'h3: next_tap = tms_s ? 4'h5 : 4'h4;
            4'h4: next_tap = tms_s ? 4'h5 : 4'h4;
            4'h5: next_tap = tms_s ? 4'h8 : 4'h6;
            4'h6: next_tap = tms_s ? 4'h7 : 4'h6;
            4'h7: next_tap = tms_s ? 4'h5 : 4'h4;
            4'h8: next_tap = tms_s ? 4'h2 : 4'h1;
            4'h9: next_tap = tms_s ? 4'h0 : 4'hA;
            4'hA: next_tap = tms_s ? 4'hC : 4'hB;
            4'hB: next_tap = tms_s ? 4'hC : 4'hB;
            4'hC: next_tap = tms_s ? 4'hF : 4'hD;
            4'hD: next_tap = tms_s ? 4'hE : 4'hD;
            4'hE: next_tap = tms_s ? 4'hC : 4'hB;
            default: next_tap = tms_s ? 4'h2 : 4'h1;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tap_state <= SCPR_TAP_RESET_ST;
        end else if (tck_rise) begin
            tap_state <= next_tap;
        end
    end

    assign TAP_STATE_O = tap_state;
endmodule // scpr_top

// ==== sim/scpr_monitor.sv ====
// scpr_monitor: pin-level checks on the serial readout block
// assumes all pins are sampled by CLK_I and RSTN_I is async active low
`timescale 1ns/1ns
module scpr_monitor
    import scpr_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic DEV_SEL_N_I,
    input wire logic OE_RESET_N_I,
    input wire logic OE_RESET_N_OE_O,
    input wire logic SERIAL_BIT_OUT_OE_O,
    input wire logic NEXT_DEVICE_SELECT_N_O,
    input wire logic CONFIG_PULSE_N_O,
    input wire logic CONFIG_PULSE_N_OE_O,
    input wire logic IN_SYSTEM_PROGRAM_MODE_I,
    input wire logic CLAMP_I,
    input wire logic CONFIG_CMD_I
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    logic [7:0] hi_cnt;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I)
            hi_cnt <= 8'h00;
        else if (CONFIG_PULSE_N_OE_O)
            hi_cnt <= hi_cnt + 8'h01;
        else
            hi_cnt <= 8'h00;
    end
    sequence cmd_edge; $rose(CONFIG_CMD_I); endsequence
    sequence pulse_on; ##[1:6] CONFIG_PULSE_N_OE_O; endsequence
    a_por_hold: assert property ($rose(RSTN_I) |-> OE_RESET_N_OE_O [*8])
        else $error("line released too early after reset");
    a_por_end: assert property ($rose(RSTN_I) |-> ##[1:120] !OE_RESET_N_OE_O)
        else $error("line never released after reset");
    a_cmd_pulse: assert property (cmd_edge |-> pulse_on)
        else $error("no config pulse after command");
    a_pulse_len: assert property ($fell(CONFIG_PULSE_N_OE_O) |->
        hi_cnt == 8'(SCPR_CFG_PULSE_CYC)) else $error("config pulse width wrong");
    a_pulse_low: assert property (CONFIG_PULSE_N_OE_O |-> !CONFIG_PULSE_N_O)
        else $error("config pulse not driven low");
    a_line_float: assert property (!OE_RESET_N_I [*5] |-> !SERIAL_BIT_OUT_OE_O)
        else $error("data driven while line low");
    a_line_next: assert property (!OE_RESET_N_I [*5] |-> NEXT_DEVICE_SELECT_N_O)
        else $error("next select low while line low");
    a_sel_float: assert property (DEV_SEL_N_I [*5] |->
        !SERIAL_BIT_OUT_OE_O && NEXT_DEVICE_SELECT_N_O) else $error("active while deselected");
    a_pgm_float: assert property ((IN_SYSTEM_PROGRAM_MODE_I && !CLAMP_I) [*5] |->
        !SERIAL_BIT_OUT_OE_O) else $error("data driven in program mode");
    a_hand_off: assert property (!NEXT_DEVICE_SELECT_N_O [*3] |-> !SERIAL_BIT_OUT_OE_O)
        else $error("data driven after hand-off");
endmodule // scpr_monitor
bind scpr_top scpr_monitor u_mon (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .DEV_SEL_N_I(DEV_SEL_N_I),
    .OE_RESET_N_I(OE_RESET_N_I), .OE_RESET_N_OE_O(OE_RESET_N_OE_O),
    .SERIAL_BIT_OUT_OE_O(SERIAL_BIT_OUT_OE_O), .NEXT_DEVICE_SELECT_N_O(NEXT_DEVICE_SELECT_N_O),
    .CONFIG_PULSE_N_O(CONFIG_PULSE_N_O), .CONFIG_PULSE_N_OE_O(CONFIG_PULSE_N_OE_O),
    .IN_SYSTEM_PROGRAM_MODE_I(IN_SYSTEM_PROGRAM_MODE_I), .CLAMP_I(CLAMP_I),
    .CONFIG_CMD_I(CONFIG_CMD_I));

// ==== sim/scpr_fpga_model.sv ====
// scpr_fpga_model: serial configuration port of the receiving fpga
// assumes it runs off the bench clock and is driven at falling edges
`timescale 1ns/1ns
module scpr_fpga_model
    import scpr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic hold_low_i,
    input  wire logic line_oe_i,
    input  wire logic data_i,
    input  wire logic data_oe_i,
    output logic      cfg_clk_o,
    output logic      line_o,
    output logic      din_o
);
    logic last = 1'b0;
    // pulled-up line: any party may pull it low
    assign line_o = !(line_oe_i || hold_low_i);
    // a floated data line shows the inverse of the last bit, never a stale copy
    assign din_o = data_oe_i ? data_i : !last;
    always_ff @(posedge clk_i) begin
        if (data_oe_i)
            last <= data_i;
    end
    initial cfg_clk_o = 1'b0;
    // clock stays low between bits; high phase kept at 4 cycles
    task automatic take_bit(input int lo, output logic b, output logic oe);
        repeat (lo) @(negedge clk_i);
        b = din_o;
        oe = data_oe_i;
        cfg_clk_o = 1'b1;
        repeat (4) @(negedge clk_i);
        cfg_clk_o = 1'b0;
    endtask
endmodule // scpr_fpga_model

// ==== sim/tb_top.sv ====
// tb_top: self-checking bench for the serial readout block
// assumes the fpga model stands on the data pin and the shared line
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb_top
    import scpr_pkg::*;
;
    logic clk, rstn, csel, sel_n, hold, pgm, clamp, tck, tms, cmd, we, pbit, b, oe;
    logic [SCPR_ADDR_W-1:0] addr;
    logic line_oe, line_drv, dout, dout_oe, nsel, cp, cp_oe;
    logic [3:0] tap;
    wire cfg_clk, line, din;
    int fails, comparisons;
    scpr_top uut (.CLK_I(clk), .RSTN_I(rstn), .CFG_CLK_I(cfg_clk), .CFG_CLK_SEL_I(csel),
        .DEV_SEL_N_I(sel_n), .OE_RESET_N_I(line), .OE_RESET_N_O(line_drv),
        .OE_RESET_N_OE_O(line_oe),
        .SERIAL_BIT_OUT_O(dout), .SERIAL_BIT_OUT_OE_O(dout_oe), .NEXT_DEVICE_SELECT_N_O(nsel),
        .CONFIG_PULSE_N_O(cp), .CONFIG_PULSE_N_OE_O(cp_oe), .IN_SYSTEM_PROGRAM_MODE_I(pgm),
        .CLAMP_I(clamp), .TCK_I(tck), .TMS_I(tms), .CONFIG_CMD_I(cmd), .TAP_STATE_O(tap),
        .PROG_WE_I(we), .PROG_ADDR_I(addr), .PROG_BIT_I(pbit));
    scpr_fpga_model fpga (.clk_i(clk), .hold_low_i(hold), .line_oe_i(line_oe), .data_i(dout),
        .data_oe_i(dout_oe), .cfg_clk_o(cfg_clk), .line_o(line), .din_o(din));
    function automatic logic p(input logic [11:0] a);
        return a[0] ^ a[4] ^ a[11];
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_oe;
        int n;
        n = 0;
        while (dout_oe !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        `CHK("data_oe", 1'b1, dout_oe)
    endtask
    task automatic conclude;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_por;
        cyc(1);
        `CHK("line_drive", 1'b1, line_oe)
        `CHK("line_level", 1'b0, line)
        `CHK("line_value", 1'b0, line_drv)
        cyc(SCPR_POR_CYC - 6);
        `CHK("line_held", 1'b1, line_oe)
        cyc(10);
        `CHK("line_free", 1'b1, line)
        $display("test por done");
    endtask
    task automatic t_load;
        pgm = 1'b1;
        // program mode reaches the write gate through the synchroniser
        cyc(2);
        for (int a = 0; a < SCPR_MEM_DEPTH; a++) begin
            cyc(1);
            we = 1'b1;
            addr = a[11:0];
            pbit = p(a[11:0]);
        end
        cyc(1);
        we = 1'b0;
        sel_n = 1'b0;
        cyc(8);
        `CHK("pgm_float", 1'b0, dout_oe)
        clamp = 1'b1;
        cyc(8);
        `CHK("clamp_drive", 1'b1, dout_oe)
        clamp = 1'b0;
        pgm = 1'b0;
        $display("test load done");
    endtask
    task automatic t_stream;
        wait_oe();
        for (int i = 0; i < SCPR_MEM_DEPTH; i++) begin
            if (i == SCPR_MEM_DEPTH - 1)
                `CHK("next_early", 1'b1, nsel)
            fpga.take_bit(6, b, oe);
            `CHK("bit", p(i[11:0]), b)
        end
        cyc(10);
        `CHK("last_float", 1'b0, dout_oe)
        `CHK("next_low", 1'b0, nsel)
        fpga.take_bit(6, b, oe);
        cyc(10);
        `CHK("extra_edge", 1'b0, dout_oe)
        sel_n = 1'b1;
        cyc(8);
        `CHK("next_desel", 1'b1, nsel)
        `CHK("standby_float", 1'b0, dout_oe)
        sel_n = 1'b0;
        wait_oe();
        fpga.take_bit(6, b, oe);
        `CHK("restart_bit", p(12'h000), b)
        $display("test stream done");
    endtask
    task automatic t_gate;
        csel = 1'b0;
        fpga.take_bit(30, b, oe);
        `CHK("unsel_bit", p(12'h001), b)
        csel = 1'b1;
        fpga.take_bit(30, b, oe);
        `CHK("held_bit", p(12'h001), b)
        fpga.take_bit(6, b, oe);
        `CHK("next_bit", p(12'h002), b)
        hold = 1'b1;
        cyc(8);
        `CHK("hold_float", 1'b0, dout_oe)
        `CHK("hold_next", 1'b1, nsel)
        hold = 1'b0;
        wait_oe();
        fpga.take_bit(6, b, oe);
        `CHK("reset_bit", p(12'h000), b)
        $display("test gate done");
    endtask
    task automatic t_cfg;
        int n;
        n = 0;
        cmd = 1'b1;
        while (cp_oe !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        `CHK("pulse_drive", 1'b1, cp_oe)
        `CHK("pulse_level", 1'b0, cp)
        n = 0;
        while (cp_oe === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        `CHK("pulse_len", SCPR_CFG_PULSE_CYC, n)
        cmd = 1'b0;
        $display("test cfg done");
    endtask
    task automatic tck_pulse(input logic m);
        tms = m;
        cyc(4);
        tck = 1'b1;
        cyc(4);
        tck = 1'b0;
    endtask
    task automatic t_tap;
        tck_pulse(1'b0);
        cyc(4);
        `CHK("tap_moved", 1'b1, tap !== SCPR_TAP_RESET_ST && !$isunknown(tap))
        repeat (5) tck_pulse(1'b1);
        cyc(4);
        `CHK("tap_reset", SCPR_TAP_RESET_ST, tap)
        $display("test tap done");
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rstn, sel_n, csel, hold, pgm, clamp} = 6'b010000;
        {tck, tms, cmd, we, pbit, addr} = '0;
        csel = 1'b1;
        cyc(16);
        rstn = 1'b1;
        t_por();
        t_load();
        t_stream();
        t_gate();
        t_cfg();
        t_tap();
        conclude();
    end
    // normal run is about 45k cycles
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule // tb_top
